// [core/lepc_params.svh]
// Offsets, field positions, reset values and event bits of the link control bank
`ifndef LEPC_PARAMS_SVH
`define LEPC_PARAMS_SVH
`define LEPC_IDX_LINK_ERR 8'hB9
`define LEPC_IDX_ENC_CRC 8'hBA
`define LEPC_IDX_RSVD_BB 8'hBB
`define LEPC_IDX_FV_MIN 8'hBC
`define LEPC_IDX_RSVD_BD 8'hBD
`define LEPC_IDX_PD_DIS 8'hBE
`define LEPC_IDX_IRQ_STS 8'hF0
`define LEPC_IDX_IRQ_MSK 8'hF1
`define LEPC_IDX_LINK_STS 8'hF2
`define LEPC_BIT_FILT_IGN 5
`define LEPC_BIT_CNT_EN 4
`define LEPC_THRESH_MSB 3
`define LEPC_BIT_ENC 7
`define LEPC_RST_LINK_ERR 6'h33
`define LEPC_RST_ENC 1'b1
`define LEPC_RSVD_ENC_LOW 7'h03
`define LEPC_RSVD_BB 8'h74
`define LEPC_RSVD_BD 8'h00
`define LEPC_RST_FV_MIN 8'h80
`define LEPC_RST_PD_DIS 8'h00
`define LEPC_RST_MSK 4'h0
`define LEPC_NUM_EV 4
`define LEPC_EV_LOST 0
`define LEPC_EV_GAIN 1
`define LEPC_EV_ERR 2
`define LEPC_EV_FS 3
`define LEPC_DC_MAX_ONES 4'h4
`endif

// [core/lepc_pkg.sv]
// Types shared by the link control bank
package lepc_pkg;
  typedef logic [7:0] lepc_byte_t;
  typedef enum logic [1:0] {
    LEPC_BUS_IDLE = 2'b01,
    LEPC_BUS_ACK = 2'b10
  } lepc_bus_e;
  typedef enum logic [2:0] {
    LEPC_LK_DOWN = 3'b001,
    LEPC_LK_UP = 3'b010,
    LEPC_LK_HOLD = 3'b100
  } lepc_lock_e;
endpackage : lepc_pkg

// [core/lepc_link_mon.sv]
// Forward link word checker, lock keeper and raw-mode frame start timer
`timescale 1ns/1ns
`include "lepc_params.svh"
module lepc_link_mon (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Synchronised link inputs
  input wire logic link_tick,
  input wire logic rx_clk0_bit,
  input wire logic rx_clk1_bit,
  input wire lepc_pkg::lepc_byte_t rx_data,
  input wire logic rx_parity_bit,
  input wire logic rx_dc_balance_bit,
  input wire logic cdr_locked,
  input wire logic filter_wait,
  input wire logic frame_valid,
  // Configuration
  input wire logic raw_mode,
  input wire logic cnt_en,
  input wire logic filt_ign,
  input wire logic [3:0] thresh,
  input wire lepc_pkg::lepc_byte_t fv_min,
  // Status and events
  output logic rx_lock,
  output logic [3:0] err_cnt,
  output logic ev_lost,
  output logic ev_gain,
  output logic ev_err,
  output logic frame_start
);
  import lepc_pkg::*;

  lepc_lock_e lk_r, lk_nxt;
  logic [3:0] cnt_r, cnt_nxt, ones;
  logic lost_r, lost_nxt, gain_r, gain_nxt, err_r, err_nxt;
  logic [7:0] fv_cnt_r, fv_cnt_nxt;
  logic armed_r, armed_nxt, fs_r, fs_nxt;
  logic word_err, counted, reach;

  always_comb
  begin
    ones = 4'h0;
    for (int i = 0; i < 8; i++)
      ones = ones + {3'b000, rx_data[i]};
  end

  // Both clock bits, parity over data and balance bit, balance bit sanity
  assign word_err = !rx_clk0_bit || rx_clk1_bit || (^{rx_data, rx_dc_balance_bit, rx_parity_bit})
    || (rx_dc_balance_bit && (ones > `LEPC_DC_MAX_ONES));
  // Only link clock edges advance the counter
  assign counted = link_tick && word_err && !(filt_ign && filter_wait);
  assign reach = !cnt_en || (({1'b0, cnt_r} + 5'h01) >= {1'b0, thresh});

  always_comb
  begin
    lk_nxt = lk_r;
    cnt_nxt = cnt_r;
    lost_nxt = 1'b0;
    gain_nxt = 1'b0;
    err_nxt = counted && (lk_r == LEPC_LK_UP);
    case (lk_r)
      LEPC_LK_DOWN:
        if (link_tick && cdr_locked)
        begin
          lk_nxt = LEPC_LK_UP;
          cnt_nxt = 4'h0;
          gain_nxt = 1'b1;
        end
      LEPC_LK_UP:
        if (!cdr_locked)
        begin
          lk_nxt = LEPC_LK_DOWN;
          cnt_nxt = 4'h0;
          lost_nxt = 1'b1;
        end
        else if (counted && reach)
        begin
          lk_nxt = LEPC_LK_HOLD;
          cnt_nxt = 4'h0;
          lost_nxt = 1'b1;
        end
        else if (counted)
          cnt_nxt = cnt_r + 4'h1;
      LEPC_LK_HOLD:
        // Relock only after the lock circuit itself restarts
        if (!cdr_locked)
          lk_nxt = LEPC_LK_DOWN;
      default:
        lk_nxt = LEPC_LK_DOWN;
    endcase
  end

  always_comb
  begin
    fv_cnt_nxt = fv_cnt_r;
    armed_nxt = armed_r;
    fs_nxt = 1'b0;
    if (!frame_valid)
    begin
      fv_cnt_nxt = 8'h00;
      armed_nxt = 1'b1;
    end
    else if (link_tick && armed_r && raw_mode)
    begin
      if (({1'b0, fv_cnt_r} + 9'h001) >= {1'b0, fv_min})
      begin
        fs_nxt = 1'b1;
        armed_nxt = 1'b0;
      end
      else
        fv_cnt_nxt = fv_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      lk_r <= LEPC_LK_DOWN;
      cnt_r <= 4'h0;
      lost_r <= 1'b0;
      gain_r <= 1'b0;
      err_r <= 1'b0;
      fv_cnt_r <= 8'h00;
      armed_r <= 1'b0;
      fs_r <= 1'b0;
    end
    else
    begin
      lk_r <= lk_nxt;
      cnt_r <= cnt_nxt;
      lost_r <= lost_nxt;
      gain_r <= gain_nxt;
      err_r <= err_nxt;
      fv_cnt_r <= fv_cnt_nxt;
      armed_r <= armed_nxt;
      fs_r <= fs_nxt;
    end
  end

  // Up state bit of the one-hot code, so the pin is a bare flop
  assign rx_lock = lk_r[1];
  assign err_cnt = cnt_r;
  assign ev_lost = lost_r;
  assign ev_gain = gain_r;
  assign ev_err = err_r;
  assign frame_start = fs_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_first_drop: assert property (
    rx_lock && cdr_locked && counted && !cnt_en |=> !rx_lock ##1 !rx_lock)
    else $error("lock kept after first error with counting off");
  a_thresh_drop: assert property (
    rx_lock && cdr_locked && counted && cnt_en && reach |=> !rx_lock && err_cnt == 4'h0)
    else $error("lock kept at error threshold");
  a_below_count: assert property (
    rx_lock && cdr_locked && counted && !reach |=> rx_lock && err_cnt == $past(err_cnt) + 4'h1)
    else $error("error below threshold not counted");
  a_filter_skip: assert property (
    rx_lock && cdr_locked && filt_ign && filter_wait |=> rx_lock && $stable(err_cnt))
    else $error("error counted in filter wait period");
  a_tick_only: assert property (
    !link_tick |=> $stable(err_cnt) || err_cnt == 4'h0)
    else $error("error count moved without link clock edge");
  a_clk_bit: assert property (
    rx_lock && cdr_locked && link_tick && !rx_clk0_bit && !cnt_en && !(filt_ign && filter_wait)
    |=> !rx_lock)
    else $error("clock bit error not detected");
  a_relock_clear: assert property (
    lk_r == LEPC_LK_DOWN && link_tick && cdr_locked |=> rx_lock && err_cnt == 4'h0)
    else $error("count not cleared on relock");
  a_fv_start: assert property (
    frame_start |-> $past(frame_valid) && $past(raw_mode)
    && (({1'b0, $past(fv_cnt_r)} + 9'h001) >= {1'b0, $past(fv_min)}))
    else $error("frame start before minimum valid time");
  a_fv_once: assert property (
    frame_start |=> !frame_start)
    else $error("frame start longer than one cycle");
endmodule : lepc_link_mon

// [core/lepc_top.sv]
// Register bank for link error counting, frame valid timing and pin pull-downs
`timescale 1ns/1ns
`include "lepc_params.svh"
// How it works
// - Each received word is checked on both clock bits, parity and the balance bit.
// - The error counter only counts up on a rising edge of the recovered link clock.
// - With counting on, lock drops when the error count reaches the threshold (reset 3).
// - With counting off, lock drops on the first error.
// - Bit 4 of the link error register turns counting on, reset value one.
// - Bit 5, reset one, makes errors during the line filter wait period be ignored.
// - In raw mode a frame start follows frame valid held for the programmed link periods.
// - A pin not in output mode gets its pull-down unless that pin's disable bit is set.
// - The pull-down register holds one disable bit per pin, reset zero.
module lepc_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Forward link, asynchronous
  input wire logic link_clk,
  input wire logic rx_clk0_bit,
  input wire logic rx_clk1_bit,
  input wire lepc_pkg::lepc_byte_t rx_data,
  input wire logic rx_parity_bit,
  input wire logic rx_dc_balance_bit,
  input wire logic cdr_locked,
  input wire logic filter_wait,
  input wire logic frame_valid,
  // Same-clock controls
  input wire logic raw_mode,
  input wire lepc_pkg::lepc_byte_t pin_output_mode,
  input wire logic info_valid,
  input wire logic info_crc_ok,
  input wire lepc_pkg::lepc_byte_t info_data,
  // Outputs
  output logic rx_lock,
  output logic frame_start,
  output lepc_pkg::lepc_byte_t pulldown_en,
  output lepc_pkg::lepc_byte_t link_info
);
  import lepc_pkg::*;

  localparam int SW = 16;

  logic [SW-1:0] sync1_r, sync2_r;
  logic lclk_d_r;
  logic s_lclk, s_clk0, s_clk1, s_par, s_dc, s_cdr, s_filt, s_fv;
  lepc_byte_t s_data;
  logic link_tick;

  lepc_bus_e bus_r, bus_nxt;
  logic wreq_r, wreq_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  lepc_byte_t idx, rd_byte;
  logic wr_go;

  logic [5:0] link_err_r, link_err_nxt;
  logic enc_r, enc_nxt;
  lepc_byte_t fv_min_r, fv_min_nxt;
  lepc_byte_t pd_dis_r, pd_dis_nxt;
  logic [`LEPC_NUM_EV-1:0] sts_r, sts_nxt, msk_r, msk_nxt, ev, clr;
  logic irq_r, irq_nxt;
  lepc_byte_t pd_en_r, pd_en_nxt;
  lepc_byte_t info_r, info_nxt;

  logic [3:0] err_cnt;
  logic ev_lost, ev_gain, ev_err;

  // Two stages for everything that arrives from the link
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      lclk_d_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {link_clk, rx_clk0_bit, rx_clk1_bit, rx_parity_bit, rx_dc_balance_bit,
        cdr_locked, filter_wait, frame_valid, rx_data};
      sync2_r <= sync1_r;
      lclk_d_r <= s_lclk;
    end
  end

  assign s_lclk = sync2_r[15];
  assign s_clk0 = sync2_r[14];
  assign s_clk1 = sync2_r[13];
  assign s_par = sync2_r[12];
  assign s_dc = sync2_r[11];
  assign s_cdr = sync2_r[10];
  assign s_filt = sync2_r[9];
  assign s_fv = sync2_r[8];
  assign s_data = sync2_r[7:0];
  // Data shares the clock's sync delay, so it is still stable at the edge
  assign link_tick = s_lclk && !lclk_d_r;

  lepc_link_mon u_mon (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .link_tick(link_tick),
    .rx_clk0_bit(s_clk0),
    .rx_clk1_bit(s_clk1),
    .rx_data(s_data),
    .rx_parity_bit(s_par),
    .rx_dc_balance_bit(s_dc),
    .cdr_locked(s_cdr),
    .filter_wait(s_filt),
    .frame_valid(s_fv),
    .raw_mode(raw_mode),
    .cnt_en(link_err_r[`LEPC_BIT_CNT_EN]),
    .filt_ign(link_err_r[`LEPC_BIT_FILT_IGN]),
    .thresh(link_err_r[`LEPC_THRESH_MSB:0]),
    .fv_min(fv_min_r),
    .rx_lock(rx_lock),
    .err_cnt(err_cnt),
    .ev_lost(ev_lost),
    .ev_gain(ev_gain),
    .ev_err(ev_err),
    .frame_start(frame_start)
  );

  assign idx = avs_address[9:2];
  // Byte lane 0 gates every write; the upper lanes carry nothing
  assign wr_go = avs_write && (bus_r == LEPC_BUS_ACK) && avs_byteenable[0];

  always_comb
  begin
    case (idx)
      `LEPC_IDX_LINK_ERR: rd_byte = {2'b00, link_err_r};
      `LEPC_IDX_ENC_CRC: rd_byte = {enc_r, `LEPC_RSVD_ENC_LOW};
      `LEPC_IDX_RSVD_BB: rd_byte = `LEPC_RSVD_BB;
      `LEPC_IDX_FV_MIN: rd_byte = fv_min_r;
      `LEPC_IDX_RSVD_BD: rd_byte = `LEPC_RSVD_BD;
      `LEPC_IDX_PD_DIS: rd_byte = pd_dis_r;
      `LEPC_IDX_IRQ_STS: rd_byte = {4'h0, sts_r};
      `LEPC_IDX_IRQ_MSK: rd_byte = {4'h0, msk_r};
      `LEPC_IDX_LINK_STS: rd_byte = {3'b000, rx_lock, err_cnt};
      default: rd_byte = 8'h00;
    endcase
  end

  // One wait state: data is latched on the request, written on the answer edge
  always_comb
  begin
    bus_nxt = bus_r;
    wreq_nxt = 1'b1;
    rdata_nxt = rdata_r;
    case (bus_r)
      LEPC_BUS_IDLE:
        if (avs_read || avs_write)
        begin
          bus_nxt = LEPC_BUS_ACK;
          wreq_nxt = 1'b0;
          rdata_nxt = {24'h000000, rd_byte};
        end
      LEPC_BUS_ACK:
        bus_nxt = LEPC_BUS_IDLE;
      default:
        bus_nxt = LEPC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      bus_r <= LEPC_BUS_IDLE;
      wreq_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      bus_r <= bus_nxt;
      wreq_r <= wreq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_waitrequest = wreq_r;
  assign avs_readdata = rdata_r;

  assign ev[`LEPC_EV_LOST] = ev_lost;
  assign ev[`LEPC_EV_GAIN] = ev_gain;
  assign ev[`LEPC_EV_ERR] = ev_err;
  assign ev[`LEPC_EV_FS] = frame_start;
  assign clr = (wr_go && idx == `LEPC_IDX_IRQ_STS) ? avs_writedata[3:0] : 4'h0;

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_pin
      assign pd_en_nxt[g] = !pin_output_mode[g] && !pd_dis_r[g];
    end
  endgenerate

  always_comb
  begin
    link_err_nxt = link_err_r;
    enc_nxt = enc_r;
    fv_min_nxt = fv_min_r;
    pd_dis_nxt = pd_dis_r;
    msk_nxt = msk_r;
    info_nxt = info_r;
    if (wr_go)
    begin
      case (idx)
        `LEPC_IDX_LINK_ERR: link_err_nxt = avs_writedata[5:0];
        `LEPC_IDX_ENC_CRC: enc_nxt = avs_writedata[`LEPC_BIT_ENC];
        `LEPC_IDX_FV_MIN: fv_min_nxt = avs_writedata[7:0];
        `LEPC_IDX_PD_DIS: pd_dis_nxt = avs_writedata[7:0];
        `LEPC_IDX_IRQ_MSK: msk_nxt = avs_writedata[3:0];
        default: msk_nxt = msk_r;
      endcase
    end
    // Encoder bit set lets packets with a failed checksum through
    if (info_valid && (info_crc_ok || enc_r))
      info_nxt = info_data;
    // New events beat a same-cycle clear
    sts_nxt = (sts_r & ~clr) | ev;
    irq_nxt = |(sts_nxt & msk_nxt);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      link_err_r <= `LEPC_RST_LINK_ERR;
      enc_r <= `LEPC_RST_ENC;
      fv_min_r <= `LEPC_RST_FV_MIN;
      pd_dis_r <= `LEPC_RST_PD_DIS;
      msk_r <= `LEPC_RST_MSK;
      sts_r <= 4'h0;
      irq_r <= 1'b0;
      pd_en_r <= 8'h00;
      info_r <= 8'h00;
    end
    else
    begin
      link_err_r <= link_err_nxt;
      enc_r <= enc_nxt;
      fv_min_r <= fv_min_nxt;
      pd_dis_r <= pd_dis_nxt;
      msk_r <= msk_nxt;
      sts_r <= sts_nxt;
      irq_r <= irq_nxt;
      pd_en_r <= pd_en_nxt;
      info_r <= info_nxt;
    end
  end

  assign irq = irq_r;
  assign pulldown_en = pd_en_r;
  assign link_info = info_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_bus_answer: assert property (
    bus_r == LEPC_BUS_IDLE && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one wait state");
  a_ctl_readback: assert property (
    bus_r == LEPC_BUS_IDLE && avs_read && idx == `LEPC_IDX_LINK_ERR
    |=> avs_readdata == {26'h0, $past(link_err_r)})
    else $error("link error control readback wrong");
  a_pd_follow: assert property (
    $past(wr_go && idx == `LEPC_IDX_PD_DIS, 2)
    |-> pulldown_en == (~$past(pin_output_mode) & ~$past(avs_writedata[7:0], 2)))
    else $error("pull-down enable does not follow disable bits");
  a_pd_output: assert property (
    pin_output_mode[0] |=> !pulldown_en[0])
    else $error("pull-down on while pin drives");
  a_sts_sticky: assert property (
    sts_r[`LEPC_EV_LOST] && !clr[`LEPC_EV_LOST] |=> sts_r[`LEPC_EV_LOST])
    else $error("status bit lost without clear");
  a_irq_level: assert property (
    irq == |(sts_r & msk_r))
    else $error("interrupt does not follow masked status");
  a_w1c_clear: assert property (
    clr[`LEPC_EV_GAIN] && !ev[`LEPC_EV_GAIN] |=> !sts_r[`LEPC_EV_GAIN])
    else $error("status bit not cleared by a written one");
  a_be_refused: assert property (
    avs_write && bus_r == LEPC_BUS_ACK && !avs_byteenable[0]
    |=> $stable(fv_min_r) && $stable(pd_dis_r))
    else $error("write without byte enable took effect");
endmodule : lepc_top

// [tb/lepc_ser_model.sv]
// Remote serializer model driving forward link words and frame valid
`timescale 1ns/1ns
module lepc_ser_model (
  // Fault and frame controls
  input wire logic [2:0] err_kind,
  input wire logic fv_req,
  // Forward link
  output logic link_clk,
  output logic rx_clk0_bit,
  output logic rx_clk1_bit,
  output lepc_pkg::lepc_byte_t rx_data,
  output logic rx_parity_bit,
  output logic rx_dc_balance_bit,
  output logic frame_valid
);
  import lepc_pkg::*;
  logic [3:0] seq = 4'h0;
  lepc_byte_t dat;
  logic dc;
  // Recovered clock runs free, phase unrelated to the system clock
  // Word pins stay unknown until the first falling edge, still inside reset
  initial
  begin
    link_clk = 1'b0;
    #3;
    forever #32 link_clk = ~link_clk;
  end
  // Change on the falling edge so words are settled at the sampling edge
  always @(negedge link_clk)
  begin
    dat = (err_kind == 3'd4) ? 8'hF8 : {4'h0, seq};
    dc = (err_kind == 3'd4);
    seq <= seq + 4'h1;
    frame_valid <= fv_req;
    rx_clk0_bit <= (err_kind != 3'd1);
    rx_clk1_bit <= (err_kind == 3'd2);
    rx_data <= dat;
    rx_dc_balance_bit <= dc;
    rx_parity_bit <= ^{dat, dc} ^ (err_kind == 3'd3);
  end
endmodule : lepc_ser_model

// [tb/lepc_top_tb.sv]
// Self-checking bench for the link control bank
`timescale 1ns/1ns
`define CHECK_EQ(nm, exp, got) \
  begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module lepc_top_tb;
  import lepc_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn, avs_read, avs_write, avs_waitrequest, irq, link_clk, rx_clk0_bit, rx_clk1_bit;
  logic rx_parity_bit, rx_dc_balance_bit, cdr_locked, filter_wait, frame_valid, raw_mode;
  logic info_valid, info_crc_ok, rx_lock, frame_start, fv_req;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [2:0] err_kind;
  lepc_byte_t rx_data, pin_output_mode, info_data, pulldown_en, link_info, rd;
  int err_count, checks;
  logic [7:0] ridx [8] = '{8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hF1, 8'h40};
  logic [7:0] rexp [8] = '{8'h33, 8'h83, 8'h74, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};

  always #4 clk_sys = ~clk_sys;

  lepc_top dut (.clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .link_clk, .rx_clk0_bit,
    .rx_clk1_bit, .rx_data, .rx_parity_bit, .rx_dc_balance_bit, .cdr_locked, .filter_wait,
    .frame_valid, .raw_mode, .pin_output_mode, .info_valid, .info_crc_ok, .info_data,
    .rx_lock, .frame_start, .pulldown_en, .link_info);

  lepc_ser_model ser (.err_kind, .fv_req, .link_clk, .rx_clk0_bit, .rx_clk1_bit, .rx_data,
    .rx_parity_bit, .rx_dc_balance_bit, .frame_valid);

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // Holds the request until waitrequest is sampled low, then idles one cycle
  task automatic bus(input logic wr, input logic [7:0] idx, input lepc_byte_t wd,
    input logic [3:0] be);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input lepc_byte_t d);
    bus(1'b1, idx, d, 4'h1);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input lepc_byte_t exp);
    bus(1'b0, idx, 8'h00, 4'h1);
    `CHECK_EQ($sformatf("reg %h", idx), exp, rd)
  endtask : rdc

  // One bad word: exactly one falling link edge falls in 8 cycles
  task automatic inject(input logic [2:0] k);
    err_kind <= k;
    cyc(8);
    err_kind <= 3'd0;
    cyc(16);
  endtask : inject

  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    while (rx_lock !== v && n < 200)
    begin
      cyc(1);
      n++;
    end
    `CHECK_EQ("rx_lock", v, rx_lock)
  endtask : wait_lock

  task automatic info(input lepc_byte_t d, input logic ok);
    info_data <= d;
    info_crc_ok <= ok;
    info_valid <= 1'b1;
    cyc(1);
    info_valid <= 1'b0;
    cyc(2);
  endtask : info

  // Pulse must land near mn link periods after frame valid rises
  task automatic fs_run(input lepc_byte_t mn, input logic raw, input int expn);
    int n, pulses, first;
    pulses = 0;
    first = 0;
    wr(8'hBC, mn);
    raw_mode <= raw;
    fv_req <= 1'b1;
    for (n = 1; n <= mn * 8 + 14; n++)
    begin
      cyc(1);
      if (frame_start === 1'b1)
      begin
        pulses++;
        if (first == 0) first = n;
      end
    end
    fv_req <= 1'b0;
    cyc(24);
    `CHECK_EQ("frame_start count", expn, pulses)
    if (expn == 1) `CHECK_EQ("frame_start delay", 1'b1, (first >= mn * 8 - 2))
  endtask : fs_run

  task automatic tally_and_finish;
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    cyc(20000);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    {rstn, avs_read, avs_write, cdr_locked, filter_wait, raw_mode, info_valid} = 7'h0;
    {info_crc_ok, fv_req, avs_address, avs_writedata, avs_byteenable} = 48'h0;
    {pin_output_mode, info_data, err_kind} = 19'h0;
    err_count = 0;
    checks = 0;
    cyc(10);
    rstn <= 1'b1;
    cyc(2);
    `CHECK_EQ("pulldown_en", 8'hFF, pulldown_en)
    for (int i = 0; i < 8; i++) rdc(ridx[i], rexp[i]);
    info(8'h5A, 1'b0);
    `CHECK_EQ("link_info", 8'h5A, link_info)
    wr(8'hBA, 8'h00);
    wr(8'h4A, 8'h10);
    rdc(8'h4A, 8'h00);
    rdc(8'hBA, 8'h03);
    info(8'h33, 1'b0);
    `CHECK_EQ("link_info", 8'h5A, link_info)
    info(8'h77, 1'b1);
    `CHECK_EQ("link_info", 8'h77, link_info)
    pin_output_mode <= 8'h0F;
    wr(8'hBB, 8'hFF);
    wr(8'hBD, 8'hFF);
    wr(8'h40, 8'hFF);
    wr(8'hBE, 8'hA5);
    wr(8'hBC, 8'h05);
    bus(1'b1, 8'hBC, 8'hEE, 4'h0);
    rdc(8'hBB, 8'h74);
    rdc(8'hBD, 8'h00);
    rdc(8'h40, 8'h00);
    rdc(8'hBE, 8'hA5);
    rdc(8'hBC, 8'h05);
    `CHECK_EQ("pulldown_en", 8'h50, pulldown_en)
    wr(8'hF1, 8'h0F);
    cdr_locked <= 1'b1;
    wait_lock(1'b1);
    rdc(8'hF2, 8'h10);
    `CHECK_EQ("irq", 1'b1, irq)
    rdc(8'hF0, 8'h02);
    wr(8'hF0, 8'h02);
    cyc(2);
    `CHECK_EQ("irq", 1'b0, irq)
    wr(8'hF1, 8'h01);
    inject(3'd1);
    rdc(8'hF2, 8'h11);
    `CHECK_EQ("irq", 1'b0, irq)
    rdc(8'hF0, 8'h04);
    inject(3'd2);
    rdc(8'hF2, 8'h12);
    inject(3'd3);
    wait_lock(1'b0);
    rdc(8'hF2, 8'h00);
    `CHECK_EQ("irq", 1'b1, irq)
    wr(8'hF0, 8'hFF);
    cdr_locked <= 1'b0;
    cyc(16);
    `CHECK_EQ("irq", 1'b0, irq)
    cdr_locked <= 1'b1;
    wait_lock(1'b1);
    rdc(8'hF2, 8'h10);
    wr(8'hB9, 8'h35);
    inject(3'd4);
    rdc(8'hF2, 8'h11);
    filter_wait <= 1'b1;
    inject(3'd1);
    rdc(8'hF2, 8'h11);
    wr(8'hB9, 8'h15);
    inject(3'd1);
    rdc(8'hF2, 8'h12);
    filter_wait <= 1'b0;
    wr(8'hB9, 8'h05);
    rdc(8'hB9, 8'h05);
    inject(3'd1);
    wait_lock(1'b0);
    wr(8'hF1, 8'h08);
    wr(8'hF0, 8'hFF);
    fs_run(8'h04, 1'b1, 1);
    `CHECK_EQ("irq", 1'b1, irq)
    rdc(8'hF0, 8'h08);
    fs_run(8'h08, 1'b1, 1);
    fs_run(8'h01, 1'b1, 1);
    fs_run(8'h04, 1'b0, 0);
    tally_and_finish();
  end
endmodule : lepc_top_tb
